// [common/qdsl_if.sv]
// Three-wire serial link plus update strobe between host and quad DAC.
// Assumes the host drives every wire; the DAC only listens.
`timescale 1ns/1ps
`default_nettype none

interface qdsl_if;
  logic serial_clock;
  logic chip_select_n;
  logic serial_data_in;
  logic simultaneous_update_strobe_n;

  modport host (
    output serial_clock,
    output chip_select_n,
    output serial_data_in,
    output simultaneous_update_strobe_n
  );

  modport dac (
    input  serial_clock,
    input  chip_select_n,
    input  serial_data_in,
    input  simultaneous_update_strobe_n
  );
endinterface

`default_nettype wire

// [common/qdsl_params.svh]
// Constants for the quad DAC serial load link: word layout, host register map, timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef QDSL_PARAMS_SVH
`define QDSL_PARAMS_SVH

// Word layout: four control bits stand above the code bits
`define QDSL_DATA_BITS      12
`define QDSL_CTRL_BITS      4
`define QDSL_SA_OFS         3
`define QDSL_SD_OFS         2
`define QDSL_AH_OFS         1
`define QDSL_AL_OFS         0
`define QDSL_CHANNELS       4
`define QDSL_ADDR_BITS      2

// Host serial word length, always sent as 16 clocks
`define QDSL_HOST_WORD_BITS 16

// Host register map (byte offsets) and field positions
`define QDSL_TX_OFS         8'h00
`define QDSL_CTRL_OFS       8'h04
`define QDSL_STAT_OFS       8'h08
`define QDSL_ADDR_LSB_BITS  8
`define QDSL_CTRL_AUTO_BIT  0
`define QDSL_CTRL_PULSE_BIT 1
`define QDSL_STAT_BUSY_BIT  0
`define QDSL_STAT_PULSE_BIT 1
`define QDSL_CTRL_RESET     1'b1

// Timing in host clock cycles
`define QDSL_HALF_PERIOD    4
`define QDSL_STROBE_CYCLES  4

`endif

// [common/qdsl_pkg.sv]
// Types shared by both ends of the quad DAC serial load link.
// Assumes qdsl_params.svh on the include path.
`include "qdsl_params.svh"

package qdsl_pkg;

  typedef enum logic [2:0] {
    QDSL_IDLE = 3'b000,
    QDSL_LEAD = 3'b001,
    QDSL_HIGH = 3'b010,
    QDSL_LOW  = 3'b011,
    QDSL_TAIL = 3'b100,
    QDSL_GAP  = 3'b101
  } qdsl_state_t;

  typedef logic [`QDSL_ADDR_BITS-1:0] qdsl_addr_t;

endpackage

// [dv/qdsl_chk.sv]
// Checker for the host side of the quad DAC link wires.
// Assumes host HALF_PERIOD and STROBE_CYCLES of 4.
`timescale 1ns/1ps
`default_nettype none
module qdsl_chk (
  // Host clock domain
  input wire logic hclk,
  input wire logic hresetn,
  // Link wires
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  input wire logic simultaneous_update_strobe_n
);
  logic       sclk_q;
  logic [5:0] rise_cnt;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sclk_q <= 1'b0;
    else sclk_q <= serial_clock;
  end

  // Rises in the current frame; cleared while deselected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rise_cnt <= 6'h00;
    else if (chip_select_n) rise_cnt <= 6'h00;
    else if (serial_clock && !sclk_q) rise_cnt <= rise_cnt + 6'h01;
  end

  a_idle_clk_low: assert property (chip_select_n |-> !serial_clock)
    else $error("link clock high while deselected");
  a_data_when_low: assert property ((!chip_select_n && $changed(serial_data_in)) |-> !serial_clock)
    else $error("data moved while link clock high");
  a_data_setup: assert property ($rose(serial_clock) |-> $past(serial_data_in, 2) == serial_data_in)
    else $error("data not settled before rising edge");
  a_high_half: assert property ($rose(serial_clock) |-> serial_clock[*4] ##1 !serial_clock)
    else $error("link clock high phase wrong");
  a_low_half: assert property (($fell(serial_clock) && !chip_select_n) |-> !serial_clock[*4])
    else $error("link clock low phase short");
  a_lead_low: assert property ($fell(chip_select_n) |-> !serial_clock[*3])
    else $error("clock rose too soon after select");
  a_frame_bits: assert property ($rose(chip_select_n) |-> rise_cnt == 6'd16)
    else $error("frame did not carry sixteen clocks");
  a_gap_hold: assert property ($rose(chip_select_n) |-> chip_select_n[*4])
    else $error("select gap too short");
  a_strobe_idle: assert property ($fell(simultaneous_update_strobe_n) |-> chip_select_n)
    else $error("update strobe inside a frame");
  a_strobe_width: assert property ($fell(simultaneous_update_strobe_n) |-> !simultaneous_update_strobe_n[*4])
    else $error("update strobe pulse short");
endmodule // qdsl_chk
`default_nettype wire

// [dv/quad_dac_serial_load_test.sv]
// Top bench: host and DAC face each other; a second short DAC is fed by a rule-breaking driver.
// Assumes host registers TX 0x00, CTRL 0x04, STATUS 0x08 and auto update after reset.
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_load_test;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, por_n, rs_n;
  logic [31:0]       haddr, hwdata, hrdata, rdv, b;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [3:0][11:0]  code_m, in_m;
  logic [3:0][9:0]   code_s, in_s;
  logic [3:0]        sd_m, sd_s;
  logic [31:0]       e_code[2][4], e_in[2][4];
  logic              e_sd[2][4];
  logic [15:0]       mon_word, last_word, w, prev;
  logic [5:0]        mon_cnt, last_cnt;
  logic [15:0]       corner[4] = '{16'h0abc, 16'h5def, 16'ha123, 16'h3fff};
  int                nbits[4] = '{16, 20, 10, 14};
  int                len, err_total, check_count;

  qdsl_if link();
  qdsl_if bad();
  qdsl_host i_qdsl_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .link(link));
  qdsl_device i_qdsl_device (.link(link), .power_on_reset_n(por_n), .zero_scale_reset_n(rs_n),
    .channel_code(code_m), .channel_shutdown(sd_m), .input_code(in_m));
  qdsl_device #(.DATA_BITS(10)) i_qdsl_device_short (.link(bad), .power_on_reset_n(por_n),
    .zero_scale_reset_n(rs_n), .channel_code(code_s), .channel_shutdown(sd_s), .input_code(in_s));
  qdsl_chk i_qdsl_chk (.hclk(hclk), .hresetn(hresetn), .serial_clock(link.serial_clock),
    .chip_select_n(link.chip_select_n), .serial_data_in(link.serial_data_in),
    .simultaneous_update_strobe_n(link.simultaneous_update_strobe_n));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Wire monitor: what the DAC should see, taken on the link clock
  always @(posedge link.serial_clock or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      last_word <= mon_word;
      last_cnt <= mon_cnt;
      mon_cnt <= 6'h00;
    end else begin
      mon_word <= {mon_word[14:0], link.serial_data_in};
      mon_cnt <= mon_cnt + 6'h01;
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_reg(string n, logic [31:0] e, logic [31:0] g);
    cmp(n, e, g);
  endtask
  task automatic check_dac(string n, logic [31:0] e, logic [31:0] g);
    cmp(n, e, g);
  endtask
  task automatic check_wire(string n, logic [31:0] e, logic [31:0] g);
    cmp(n, e, g);
  endtask

  // Ready and read data are taken at the rising edge that completes the phase
  task automatic wait_rdy(output logic [31:0] d);
    int m;
    m = 0;
    do begin
      @(posedge hclk);
      m++;
    end while (hreadyout !== 1'b1 && m < 2000);
    if (hreadyout !== 1'b1) begin
      err_total++;
      $display("[ERR] hready expected 1 seen 0");
    end
    d = hrdata;
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy(rd);
  endtask

  task automatic wait_idle;
    int m;
    m = 0;
    do begin
      ahb(1'b0, 8'h08, 32'h0, rdv);
      m++;
    end while (rdv[0] !== 1'b0 && m < 300);
    if (rdv[0] !== 1'b0) begin
      err_total++;
      $display("[ERR] busy expected 0 seen 1");
    end
  endtask

  function automatic void apply(int d, logic [15:0] x, bit upd);
    int nb;
    int a;
    nb = d ? 10 : 12;
    a = (x >> nb) & 3;
    e_in[d][a] = x & ((1 << nb) - 1);
    for (int i = 0; i < 4; i++) begin
      if (x[nb + 3]) e_sd[d][i] = 1'b1;
      else if (i == a) e_sd[d][i] = x[nb + 2];
      if (upd) e_code[d][i] = e_in[d][i];
    end
  endfunction

  task automatic check_dev(int d);
    for (int i = 0; i < 4; i++) begin
      check_dac("code", e_code[d][i], d ? 32'(code_s[i]) : 32'(code_m[i]));
      check_dac("input", e_in[d][i], d ? 32'(in_s[i]) : 32'(in_m[i]));
      check_dac("shutdown", 32'(e_sd[d][i]), d ? 32'(sd_s[i]) : 32'(sd_m[i]));
    end
  endtask

  // Deliberately clocks while deselected before each frame
  task automatic bad_frame(logic [31:0] v, int n);
    #3;
    repeat (3) begin
      bad.serial_data_in = 1'($urandom);
      #40 bad.serial_clock = 1'b1;
      #40 bad.serial_clock = 1'b0;
    end
    bad.chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      bad.serial_data_in = v[i];
      #40 bad.serial_clock = 1'b1;
      #40 bad.serial_clock = 1'b0;
    end
    #40 bad.chip_select_n = 1'b1;
    bad.serial_data_in = ~bad.serial_data_in;
    #80;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    $display("[ERR] watchdog expected done seen hang");
    test_done();
  end

  initial begin
    hresetn = 1'b0;
    por_n = 1'b0;
    rs_n = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    bad.serial_clock = 1'b0;
    bad.chip_select_n = 1'b1;
    bad.serial_data_in = 1'b0;
    bad.simultaneous_update_strobe_n = 1'b0;
    mon_cnt = 6'h00;
    mon_word = 16'h0;
    e_code = '{default: '0};
    e_in = '{default: '0};
    e_sd = '{default: 1'b0};
    void'($urandom(32'h1f4d));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 8'h04, 32'h0, rdv);
    check_reg("ctrl", 32'h1, rdv);
    check_reg("hresp", 32'h0, 32'(hresp));
    ahb(1'b0, 8'h08, 32'h0, rdv);
    check_reg("status", 32'h0, rdv);
    ahb(1'b0, 8'h0c, 32'h0, rdv);
    check_reg("unmapped", 32'h0, rdv);
    check_dev(0);
    check_dev(1);
    // Back-to-back words: each write stalls until the previous frame is out
    for (int k = 0; k <= 20; k++) begin
      if (k < 20) begin
        w = (k < 4) ? corner[k] : 16'($urandom);
        ahb(1'b1, 8'h00, {16'($urandom), w}, rdv);
      end else wait_idle();
      if (k > 0) begin
        check_wire("sdi_word", 32'(prev), 32'(last_word));
        check_wire("clk_count", 32'd16, 32'(last_cnt));
        apply(0, prev, 1'b1);
        check_dev(0);
      end
      prev = w;
    end
    ahb(1'b0, 8'h00, 32'h0, rdv);
    check_reg("tx_readback", 32'(prev), rdv);
    // Manual mode: codes wait in the input registers until the pulse
    ahb(1'b1, 8'h04, 32'h0, rdv);
    w = 16'h2777;
    ahb(1'b1, 8'h00, 32'(w), rdv);
    wait_idle();
    apply(0, w, 1'b0);
    check_dev(0);
    ahb(1'b1, 8'h10, 32'h1, rdv);
    ahb(1'b0, 8'h04, 32'h0, rdv);
    check_reg("ctrl_manual", 32'h0, rdv & 32'h1);
    ahb(1'b1, 8'h04, 32'h2, rdv);
    ahb(1'b0, 8'h08, 32'h0, rdv);
    check_reg("status_pulse", 32'h3, rdv);
    wait_idle();
    e_code[0] = e_in[0];
    check_dev(0);
    ahb(1'b1, 8'h04, 32'h1, rdv);
    // Zero-scale reset in mid-frame; the rest of the frame is too short to load
    ahb(1'b1, 8'h00, 32'h3abc, rdv);
    repeat (40) @(posedge hclk);
    rs_n <= 1'b0;
    repeat (2) @(posedge hclk);
    rs_n <= 1'b1;
    wait_idle();
    e_code = '{default: '0};
    e_in = '{default: '0};
    e_sd = '{default: 1'b0};
    check_dev(0);
    check_dev(1);
    // Short variant: exact, excess and short frames
    for (int k = 0; k < 8; k++) begin
      len = nbits[k % 4];
      b = $urandom;
      bad_frame(b, len);
      if (len >= 14) apply(1, b[15:0], 1'b1);
      check_dev(1);
    end
    test_done();
  end
endmodule // quad_dac_serial_load_test
`default_nettype wire

// [rtl/qdsl_device.sv]
// Quad DAC serial load logic: shift, decode, input and output registers.
// Assumes the host paces the link and keeps chip select and the
// update strobe from moving at the same instant.
//
// What this block does
// - Power-up clears input and output registers
// - Outputs stay zero until valid word loaded
// - Shift 16 or 14 bits on rising clock
// - Update automatically or by update strobe
// - Short variant keeps last 14 bits only
// - Host sends most significant bit first
// - Host holds select low across both bytes
// - Select rising loads word into addressed channel
// - Host changes data on falling clock edge
// - Host runs as mode zero master
// - Only newest word bits count at load
// - Two address bits pick one of four
// - Shutdown bits: all, or addressed channel
// - Zero-scale reset clears registers asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "qdsl_params.svh"

module qdsl_device
  import qdsl_pkg::*;
#(
  parameter int DATA_BITS = `QDSL_DATA_BITS
) (
  // Serial link, clocked by the host
  qdsl_if.dac                                     link,
  // Resets
  input  wire logic                               power_on_reset_n,
  input  wire logic                               zero_scale_reset_n,
  // Channel outputs
  output logic [`QDSL_CHANNELS-1:0][DATA_BITS-1:0] channel_code,
  output logic [`QDSL_CHANNELS-1:0]                channel_shutdown,
  // Pending codes not yet moved to the outputs
  output logic [`QDSL_CHANNELS-1:0][DATA_BITS-1:0] input_code
);

  localparam int WORD_BITS = DATA_BITS + `QDSL_CTRL_BITS;
  localparam int CNT_W     = $clog2(WORD_BITS + 1);
  localparam logic [CNT_W-1:0] WORD_FULL = CNT_W'(WORD_BITS);
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

  logic                                      clear_n;
  logic                                      frame_first_reg;
  logic [CNT_W-1:0]                          bit_count_reg;
  logic [WORD_BITS-1:0]                      shift_word;
  logic                                      word_valid;
  logic                                      all_off;
  logic                                      one_off;
  qdsl_addr_t                                target;
  logic [DATA_BITS-1:0]                      code_in;
  logic [`QDSL_CHANNELS-1:0][DATA_BITS-1:0]  input_reg;
  logic [`QDSL_CHANNELS-1:0][DATA_BITS-1:0]  input_next;
  logic [`QDSL_CHANNELS-1:0]                 shut_reg;
  logic [`QDSL_CHANNELS-1:0]                 shut_next;
  logic [`QDSL_CHANNELS-1:0][DATA_BITS-1:0]  dac_reg;
  logic                                      dac_load_clk;

  // Either reset empties every register without any clock
  assign clear_n = power_on_reset_n & zero_scale_reset_n;

  // Link-side shift register; chip select high freezes it
  qdsl_shift #(
    .WIDTH    (WORD_BITS)
  ) u_shift (
    .shift_clk (link.serial_clock),
    .clear_n   (clear_n),
    .shift_en  (~link.chip_select_n),
    .bit_in    (link.serial_data_in),
    .word      (shift_word)
  );

  // Marks that the next clock edge opens a new frame.
  // Chip select high sets it without a clock, since the link clock
  // stands still between frames.
  always_ff @(posedge link.serial_clock or negedge clear_n or posedge link.chip_select_n) begin
    if (!clear_n) begin
      frame_first_reg <= 1'b1;
    end else if (link.chip_select_n) begin
      frame_first_reg <= 1'b1;
    end else begin
      frame_first_reg <= 1'b0;
    end
  end

  // Bits seen in this frame, saturating at one word; excess bits
  // just push old ones out of the shift register
  always_ff @(posedge link.serial_clock or negedge clear_n) begin
    if (!clear_n) begin
      bit_count_reg <= '0;
    end else if (!link.chip_select_n) begin
      if (frame_first_reg) begin
        bit_count_reg <= CNT_ONE;
      end else if (bit_count_reg != WORD_FULL) begin
        bit_count_reg <= bit_count_reg + CNT_ONE;
      end
    end
  end

  // A short frame never loads anything
  assign word_valid = (bit_count_reg == WORD_FULL);

  // Field decode of the newest WORD_BITS bits; with the 10-bit code
  // the two leading bits of a 16-clock frame have already fallen off
  assign all_off = shift_word[DATA_BITS + `QDSL_SA_OFS];
  assign one_off = shift_word[DATA_BITS + `QDSL_SD_OFS];
  assign target  = {shift_word[DATA_BITS + `QDSL_AH_OFS],
                    shift_word[DATA_BITS + `QDSL_AL_OFS]};
  assign code_in = shift_word[DATA_BITS-1:0];

  // Register contents after a load of the current word
  always_comb begin
    input_next = input_reg;
    shut_next  = shut_reg;
    if (word_valid) begin
      input_next[target] = code_in;
      if (all_off) begin
        shut_next = '1;
      end else begin
        shut_next[target] = one_off;
      end
    end
  end

  // Input registers and shutdown state load when chip select rises
  always_ff @(posedge link.chip_select_n or negedge clear_n) begin
    if (!clear_n) begin
      input_reg <= '0;
    end else begin
      input_reg <= input_next;
    end
  end

  always_ff @(posedge link.chip_select_n or negedge clear_n) begin
    if (!clear_n) begin
      shut_reg <= '0;
    end else begin
      shut_reg <= shut_next;
    end
  end

  // Output register load edge: with the strobe held low it follows
  // chip select (automatic update); with chip select high a falling
  // strobe moves all channels at once. The host must not move both
  // wires together, or this gated edge can glitch.
  assign dac_load_clk = link.chip_select_n & ~link.simultaneous_update_strobe_n;

  // Loading from input_next makes the automatic case take the new
  // word on the same edge as the input register. A later strobe may
  // re-apply an already loaded word, which changes nothing.
  always_ff @(posedge dac_load_clk or negedge clear_n) begin
    if (!clear_n) begin
      dac_reg <= '0;
    end else begin
      dac_reg <= input_next;
    end
  end

  assign channel_code     = dac_reg;
  assign channel_shutdown = shut_reg;
  assign input_code       = input_reg;

endmodule // qdsl_device

`default_nettype wire

// [rtl/qdsl_host.sv]
// Host end: AHB-Lite register slave that drives the three-wire link
// and the update strobe, making the link clock by a divider.
// Assumes one AHB master, single word transfers, OKAY only.
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "qdsl_params.svh"

module qdsl_host
  import qdsl_pkg::*;
#(
  parameter int WORD_BITS     = `QDSL_HOST_WORD_BITS,
  parameter int HALF_PERIOD   = `QDSL_HALF_PERIOD,
  parameter int STROBE_CYCLES = `QDSL_STROBE_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Link to the DAC
  qdsl_if.host             link
);

  localparam int DIV_W = $clog2(HALF_PERIOD + 1);
  localparam int BIT_W = $clog2(WORD_BITS + 1);
  localparam int STB_W = $clog2(STROBE_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(HALF_PERIOD - 1);
  localparam logic [STB_W-1:0] STB_LOAD = STB_W'(STROBE_CYCLES - 1);

  qdsl_state_t                          state_reg;
  logic [DIV_W-1:0]                     div_reg;
  logic [BIT_W-1:0]                     bits_left_reg;
  logic [WORD_BITS-1:0]                 tx_reg;
  logic [WORD_BITS-1:0]                 out_reg;
  logic                                 sclk_reg;
  logic                                 cs_n_reg;
  logic                                 sdi_reg;
  logic                                 auto_reg;
  logic [STB_W-1:0]                     stb_cnt_reg;
  logic                                 pulse_reg;
  logic                                 dp_valid_reg;
  logic                                 dp_write_reg;
  logic [`QDSL_ADDR_LSB_BITS-1:0]       dp_addr_reg;
  logic                                 addr_take;
  logic                                 busy;
  logic                                 tick;
  logic                                 tx_write;
  logic                                 tx_go;
  logic                                 ctrl_write;

  assign busy       = (state_reg != QDSL_IDLE) || pulse_reg;
  assign tick       = (div_reg == '0);
  assign addr_take  = hsel && hready && htrans[1];
  assign tx_write   = dp_valid_reg && dp_write_reg && (dp_addr_reg == `QDSL_TX_OFS);
  assign ctrl_write = dp_valid_reg && dp_write_reg && (dp_addr_reg == `QDSL_CTRL_OFS);
  // A word written while a frame runs waits in a stalled data phase
  assign hreadyout  = !(tx_write && busy);
  assign tx_go      = tx_write && !busy;
  assign hresp      = 1'b0;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= '0;
    end else if (hready) begin
      dp_valid_reg <= addr_take;
      dp_write_reg <= hwrite;
      dp_addr_reg  <= haddr[`QDSL_ADDR_LSB_BITS-1:0];
    end
  end

  // Read data registered at the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_take && !hwrite) begin
      hrdata <= '0;
      unique case (haddr[`QDSL_ADDR_LSB_BITS-1:0])
        `QDSL_TX_OFS:   hrdata[WORD_BITS-1:0] <= tx_reg;
        `QDSL_CTRL_OFS: hrdata[`QDSL_CTRL_AUTO_BIT] <= auto_reg;
        `QDSL_STAT_OFS: begin
          hrdata[`QDSL_STAT_BUSY_BIT]  <= busy;
          hrdata[`QDSL_STAT_PULSE_BIT] <= pulse_reg;
        end
        default:        hrdata <= '0;
      endcase
    end
  end

  // Update strobe: held low in automatic mode, or pulsed on a request made while the frame sequencer is idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_reg    <= `QDSL_CTRL_RESET;
      pulse_reg   <= 1'b0;
      stb_cnt_reg <= '0;
    end else begin
      if (ctrl_write) begin
        auto_reg <= hwdata[`QDSL_CTRL_AUTO_BIT];
      end
      if (pulse_reg) begin
        stb_cnt_reg <= stb_cnt_reg - STB_W'(1);
        pulse_reg   <= (stb_cnt_reg != '0);
      end else if (ctrl_write && hwdata[`QDSL_CTRL_PULSE_BIT] && state_reg == QDSL_IDLE) begin
        pulse_reg   <= 1'b1;
        stb_cnt_reg <= STB_LOAD;
      end
    end
  end

  // Last word written, kept for readback
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_reg <= '0;
    end else if (tx_go) begin
      tx_reg <= hwdata[WORD_BITS-1:0];
    end
  end

  // Frame sequencer: clock idles low, data moves on the falling edge,
  // select stays low over all 16 clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= QDSL_IDLE;
      div_reg       <= '0;
      bits_left_reg <= '0;
      out_reg       <= '0;
      sclk_reg      <= 1'b0;
      cs_n_reg      <= 1'b1;
      sdi_reg       <= 1'b0;
    end else begin
      div_reg <= tick ? DIV_LOAD : div_reg - DIV_W'(1);
      unique case (state_reg)
        QDSL_IDLE: begin
          if (tx_go) begin
            out_reg       <= hwdata[WORD_BITS-1:0];
            sdi_reg       <= hwdata[WORD_BITS-1];
            cs_n_reg      <= 1'b0;
            bits_left_reg <= BIT_W'(WORD_BITS - 1);
            div_reg       <= DIV_LOAD;
            state_reg     <= QDSL_LEAD;
          end
        end
        QDSL_LEAD, QDSL_LOW: begin
          if (tick) begin
            sclk_reg  <= 1'b1;
            state_reg <= QDSL_HIGH;
          end
        end
        QDSL_HIGH: begin
          if (tick) begin
            sclk_reg <= 1'b0;
            if (bits_left_reg == '0) begin
              state_reg <= QDSL_TAIL;
            end else begin
              out_reg       <= {out_reg[WORD_BITS-2:0], 1'b0};
              sdi_reg       <= out_reg[WORD_BITS-2];
              bits_left_reg <= bits_left_reg - BIT_W'(1);
              state_reg     <= QDSL_LOW;
            end
          end
        end
        QDSL_TAIL: begin
          if (tick) begin
            cs_n_reg  <= 1'b1;
            state_reg <= QDSL_GAP;
          end
        end
        QDSL_GAP: begin
          if (tick) begin
            state_reg <= QDSL_IDLE;
          end
        end
        default: state_reg <= QDSL_IDLE;
      endcase
    end
  end

  assign link.serial_clock                 = sclk_reg;
  assign link.chip_select_n                = cs_n_reg;
  assign link.serial_data_in               = sdi_reg;
  assign link.simultaneous_update_strobe_n = ~(auto_reg | pulse_reg);

endmodule // qdsl_host

`default_nettype wire

// [rtl/qdsl_shift.sv]
// Serial input shift register that keeps the last WIDTH bits, MSB first.
// Assumes clock and enable come from the same link domain.
`timescale 1ns/1ps
`default_nettype none

module qdsl_shift #(
  parameter int WIDTH = 16
) (
  // Link clock and clear
  input  wire logic             shift_clk,
  input  wire logic             clear_n,
  // Serial input
  input  wire logic             shift_en,
  input  wire logic             bit_in,
  // Captured bits
  output logic [WIDTH-1:0]      word
);

  // Older bits fall off the top, so only the newest WIDTH survive
  always_ff @(posedge shift_clk or negedge clear_n) begin
    if (!clear_n) begin
      word <= '0;
    end else if (shift_en) begin
      word <= {word[WIDTH-2:0], bit_in};
    end
  end

endmodule // qdsl_shift

`default_nettype wire
